/* File: rtl/cltd_pkg.sv */
package cltd_pkg;
  // Register map, byte addresses
  localparam logic [7:0] ADDR_ACC_FIRST = 8'h00;
  localparam logic [7:0] ADDR_ACC_SECOND = 8'h04;
  localparam logic [7:0] ADDR_OPR_FIRST = 8'h08;
  localparam logic [7:0] ADDR_OPR_SECOND = 8'h0C;
  localparam logic [7:0] ADDR_QUE_FIRST = 8'h10;
  localparam logic [7:0] ADDR_QUE_SECOND = 8'h14;
  localparam logic [7:0] ADDR_CTRL = 8'h18;
  localparam logic [7:0] ADDR_STAT = 8'h1C;
  localparam logic [7:0] ADDR_LATCH = 8'h20;
  localparam logic [7:0] ADDR_SETUP = 8'h24;
  localparam logic [7:0] ADDR_POLY = 8'h28;
  localparam logic [7:0] ADDR_OUTSEL = 8'h2C;
  localparam logic [7:0] ADDR_CMPMASK = 8'h30;
  localparam logic [7:0] ADDR_CLKEN = 8'h34;
  localparam logic [7:0] ADDR_ORMASK = 8'h38;
  localparam logic [7:0] ADDR_CFG_BASE = 8'h40;
  // Reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] LATCH_RST = 8'h00;
  localparam logic [9:0] SETUP_RST = 10'h01C;
  localparam logic [7:0] POLY_RST = 8'h00;
  localparam logic [23:0] OUTSEL_RST = 24'h000000;
  localparam logic [15:0] CMPMASK_RST = 16'hFFFF;
  localparam logic [7:0] CLKEN_RST = 8'h0F;
  localparam logic [7:0] ORMASK_RST = 8'h00;
  localparam logic [15:0] CFG_RST = 16'h0000;
  // Setup register fields
  localparam int SET_MSB_LO = 2;
  localparam int SET_CH_CARRY = 5;
  localparam int SET_CH_SHIFT = 6;
  localparam int SET_CH_COND = 7;
  localparam int SET_CMP0_PAIR = 8;
  localparam int SET_CMP1_PAIR = 9;
  // Clock enable register fields
  localparam int CLK_DP = 0;
  localparam int CLK_ST = 1;
  localparam int CLK_PLD_LO = 2;
  localparam int CLK_FOLLOW_LO = 4;
  // Routing input positions
  localparam int RIN_SERIAL = 3;
  localparam int RIN_CRC = 4;
  localparam int RIN_ENABLE = 5;
  // Condition indices
  localparam int COND_EQ0 = 0;
  localparam int COND_LT0 = 1;
  localparam int COND_EQ1 = 2;
  localparam int COND_LT1 = 3;
  localparam int COND_ZERO0 = 4;
  localparam int COND_ONES0 = 5;
  localparam int COND_OVF = 6;
  localparam int COND_CARRY = 7;
  localparam int COND_SHOUT = 8;
  localparam int COND_Q0_EMPTY = 9;
  localparam int COND_Q0_FULL = 10;
  localparam int COND_Q1_EMPTY = 11;
  localparam int COND_Q1_FULL = 12;
  localparam int COND_ZERO1 = 13;
  localparam logic [2:0] QDEPTH = 3'h4;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {ALU_INC, ALU_DEC, ALU_ADD, ALU_SUB, ALU_AND, ALU_OR, ALU_XOR,
    ALU_PASS} cltd_alu_e;
  typedef enum logic [1:0] {SH_NONE, SH_LEFT, SH_RIGHT, SH_SWAP} cltd_shift_e;
  typedef struct packed {
    logic fifo_xfer; logic mask_en; logic crc_en; logic sin_sel; logic cin_sel;
    cltd_shift_e shift; logic [1:0] dest; logic [1:0] srcb; logic [1:0] srca;
    cltd_alu_e func;
  } cltd_cfg_s;
  typedef struct packed {
    logic awvalid; logic [7:0] awaddr; logic wvalid; logic [31:0] wdata;
    logic [3:0] wstrb; logic bready; logic arvalid; logic [7:0] araddr; logic rready;
  } cltd_axi_req_s;
  typedef struct packed {
    logic awready; logic wready; logic bvalid; logic [1:0] bresp;
    logic arready; logic rvalid; logic [31:0] rdata; logic [1:0] rresp;
  } cltd_axi_rsp_s;
  typedef struct packed {
    logic carry; logic shift; logic eq; logic lt; logic zero;
  } cltd_chain_s;
endpackage : cltd_pkg

/* File: rtl/cltd_datapath.sv */
`timescale 1ns/1ps
`default_nettype none
module cltd_datapath
  import cltd_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_b,
  input wire cltd_axi_req_s axi_req,
  output var cltd_axi_rsp_s axi_rsp,
  input wire logic [5:0] route_in,
  output var logic [5:0] route_out,
  input wire cltd_chain_s chain_in,
  output var cltd_chain_s chain_out,
  input wire logic [3:0] status_in,
  output var logic [7:0] ctrl_out,
  output var logic [1:0] pld_clk_en
);
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] width_mask(input logic [2:0] m);
    logic [8:0] t;
    t = (9'h002 << m) - 9'h001;
    return t[7:0];
  endfunction : width_mask

  function automatic logic [31:0] strb_merge(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) begin
        r[8*b+:8] = nw[8*b+:8];
      end
    end
    return r;
  endfunction : strb_merge

  function automatic logic addr_ok(input logic [7:0] a);
    logic ok;
    ok = (a[1:0] == 2'h0) && ((a <= ADDR_ORMASK) || (a[7:5] == ADDR_CFG_BASE[7:5]));
    return ok;
  endfunction : addr_ok

  ////////////////////////////////////////////////////////////////////////////
  logic [7:0] acc_first_r, acc_second_r, operand_reg_first_r, operand_reg_second_r;
  logic [7:0] ctrl_r, latm_r, sticky_r, poly_r, clken_r, ormask_r;
  logic [9:0] setup_r;
  logic [23:0] outsel_r;
  logic [15:0] cmpmask_r;
  logic [15:0] cfg_ram [0:7];
  logic [7:0] q_mem [0:1][0:3];
  logic [1:0] q_wp [0:1];
  logic [1:0] q_rp [0:1];
  logic [2:0] q_cnt [0:1];
  logic carry_r, shout_r;
  logic awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
  logic [1:0] bresp_r, rresp_r;
  logic [7:0] awaddr_r;
  logic [31:0] wdata_r, rdata_r, rd_val;
  logic [3:0] wstrb_r;
  logic [5:0] route_out_r;
  cltd_chain_s chain_out_r;
  logic [1:0] pld_en_r;
  cltd_cfg_s cfg;
  logic dp_act, st_act, wr_go, rd_go, stat_rd, cin, sin, cout, so, ov, fb;
  logic [2:0] msb;
  logic [7:0] wm, opa, opb, bval, alu_raw, shv, alu_res, ra, wa, stat_raw, stat_view;
  logic [8:0] sum9;
  logic [15:0] cond;
  logic [1:0] q_full, q_empty, q_push, q_pop, dp_pop;
  logic [7:0] q_din [0:1];
  logic [7:0] q_head [0:1];

  assign axi_rsp = '{awready: awready_r, wready: wready_r, bvalid: bvalid_r, bresp: bresp_r,
                     arready: arready_r, rvalid: rvalid_r, rdata: rdata_r, rresp: rresp_r};
  assign route_out = route_out_r;
  assign chain_out = chain_out_r;
  assign ctrl_out = ctrl_r;
  assign pld_clk_en = pld_en_r;

  ////////////////////////////////////////////////////////////////////////////
  // Sub-block enables, optionally following control bit 0
  assign dp_act = clken_r[CLK_DP] & (~clken_r[CLK_FOLLOW_LO] | ctrl_r[0])
                  & route_in[RIN_ENABLE];
  assign st_act = clken_r[CLK_ST] & (~clken_r[CLK_FOLLOW_LO+1] | ctrl_r[0]);
  assign cfg = cltd_cfg_s'(cfg_ram[route_in[2:0]]);
  assign msb = setup_r[SET_MSB_LO+:3];
  assign wm = width_mask(msb);

  // Operand selection
  always_comb begin
    unique case (cfg.srca)
      2'h0: opa = acc_first_r & wm;
      2'h1: opa = acc_second_r & wm;
      2'h2: opa = operand_reg_first_r & wm;
      2'h3: opa = operand_reg_second_r & wm;
    endcase
    unique case (cfg.srcb)
      2'h0: opb = operand_reg_first_r & wm;
      2'h1: opb = operand_reg_second_r & wm;
      2'h2: opb = acc_first_r & wm;
      2'h3: opb = acc_second_r & wm;
    endcase
  end

  assign cin = cfg.cin_sel ? carry_r
             : (setup_r[SET_CH_CARRY] ? chain_in.carry : (cfg.func == ALU_SUB));
  assign sin = cfg.sin_sel ? shout_r
             : (setup_r[SET_CH_SHIFT] ? chain_in.shift : route_in[RIN_SERIAL]);

  // ALU core
  always_comb begin
    bval = 8'h00;
    sum9 = 9'h000;
    unique case (cfg.func)
      ALU_INC: sum9 = {1'b0, opa} + 9'h001;
      ALU_DEC: begin
        bval = wm;
        sum9 = {1'b0, opa} + {1'b0, wm};
      end
      ALU_ADD: begin
        bval = opb;
        sum9 = {1'b0, opa} + {1'b0, opb} + {8'h00, cin};
      end
      ALU_SUB: begin
        bval = ~opb & wm;
        sum9 = {1'b0, opa} + {1'b0, bval} + {8'h00, cin};
      end
      ALU_AND: sum9 = {1'b0, opa & opb};
      ALU_OR: sum9 = {1'b0, opa | opb};
      ALU_XOR: sum9 = {1'b0, opa ^ opb};
      ALU_PASS: sum9 = {1'b0, opa};
    endcase
  end

  assign alu_raw = sum9[7:0] & wm;
  assign cout = (cfg.func <= ALU_SUB) & sum9[{1'b0, msb} + 4'h1];
  assign ov = (cfg.func <= ALU_SUB) & ~(opa[msb] ^ bval[msb]) & (opa[msb] ^ sum9[msb]);
  assign fb = opa[msb] ^ route_in[RIN_CRC];

  // Shift stage, CRC step, OR mask
  always_comb begin
    so = 1'b0;
    shv = alu_raw;
    if (cfg.crc_en) begin
      shv = ((opa << 1) & wm) ^ (fb ? (poly_r & wm) : 8'h00);
      so = fb;
    end else begin
      unique case (cfg.shift)
        SH_NONE: shv = alu_raw;
        SH_LEFT: begin
          shv = ((alu_raw << 1) | {7'h00, sin}) & wm;
          so = alu_raw[msb];
        end
        SH_RIGHT: begin
          shv = (alu_raw >> 1) | (sin ? (8'h01 << msb) : 8'h00);
          so = alu_raw[0];
        end
        SH_SWAP: shv = {alu_raw[3:0], alu_raw[7:4]} & wm;
      endcase
    end
    alu_res = cfg.mask_en ? (shv | ormask_r) : shv;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Conditions
  always_comb begin
    logic [7:0] b0, b1;
    logic e0, l0, e1, l1;
    b0 = setup_r[SET_CMP0_PAIR] ? acc_second_r : operand_reg_first_r;
    b1 = setup_r[SET_CMP1_PAIR] ? acc_first_r : operand_reg_second_r;
    e0 = (acc_first_r & cmpmask_r[7:0]) == (b0 & cmpmask_r[7:0]);
    l0 = (acc_first_r & cmpmask_r[7:0]) < (b0 & cmpmask_r[7:0]);
    e1 = (acc_second_r & cmpmask_r[15:8]) == (b1 & cmpmask_r[15:8]);
    l1 = (acc_second_r & cmpmask_r[15:8]) < (b1 & cmpmask_r[15:8]);
    cond = 16'h0000;
    cond[COND_EQ0] = e0 & (~setup_r[SET_CH_COND] | chain_in.eq);
    cond[COND_LT0] = l0 | (e0 & setup_r[SET_CH_COND] & chain_in.lt);
    cond[COND_EQ1] = e1;
    cond[COND_LT1] = l1;
    cond[COND_ZERO0] = ((acc_first_r & wm) == 8'h00)
                       & (~setup_r[SET_CH_COND] | chain_in.zero);
    cond[COND_ONES0] = (acc_first_r & wm) == wm;
    cond[COND_OVF] = ov;
    cond[COND_CARRY] = cout;
    cond[COND_SHOUT] = so;
    cond[COND_Q0_EMPTY] = q_empty[0];
    cond[COND_Q0_FULL] = q_full[0];
    cond[COND_Q1_EMPTY] = q_empty[1];
    cond[COND_Q1_FULL] = q_full[1];
    cond[COND_ZERO1] = (acc_second_r & wm) == 8'h00;
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      route_out_r <= 6'h00;
      chain_out_r <= '0;
      pld_en_r <= 2'h0;
    end else begin
      for (int j = 0; j < 6; j++) begin
        route_out_r[j] <= cond[outsel_r[4*j+:4]];
      end
      chain_out_r <= '{carry: cout, shift: so, eq: cond[COND_EQ0], lt: cond[COND_LT0],
                       zero: cond[COND_ZERO0]};
      pld_en_r <= clken_r[CLK_PLD_LO+:2]
                  & ~(clken_r[CLK_FOLLOW_LO+2+:2] & {2{~ctrl_r[0]}});
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Queues
  assign wa = awaddr_r;
  assign ra = axi_req.araddr;
  assign wr_go = ~awready_r & ~wready_r & ~bvalid_r;
  assign rd_go = axi_req.arvalid & arready_r;
  assign q_din[0] = setup_r[0] ? acc_first_r : wdata_r[7:0];
  assign q_din[1] = setup_r[1] ? acc_second_r : wdata_r[7:0];

  always_comb begin
    for (int i = 0; i < 2; i++) begin
      q_full[i] = q_cnt[i] == QDEPTH;
      q_empty[i] = q_cnt[i] == 3'h0;
      q_head[i] = q_mem[i][q_rp[i]];
      dp_pop[i] = dp_act & cfg.fifo_xfer & ~setup_r[i] & ~q_empty[i];
      q_push[i] = ~q_full[i] & (setup_r[i] ? (dp_act & cfg.fifo_xfer)
                  : (wr_go & wstrb_r[0] & (wa == (i == 0 ? ADDR_QUE_FIRST : ADDR_QUE_SECOND))));
      q_pop[i] = dp_pop[i] | (setup_r[i] & ~q_empty[i] & rd_go
                 & (ra == (i == 0 ? ADDR_QUE_FIRST : ADDR_QUE_SECOND)));
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      for (int i = 0; i < 2; i++) begin
        q_wp[i] <= 2'h0;
        q_rp[i] <= 2'h0;
        q_cnt[i] <= 3'h0;
      end
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (q_push[i]) begin
          q_mem[i][q_wp[i]] <= q_din[i];
          q_wp[i] <= q_wp[i] + 2'h1;
        end
        if (q_pop[i]) begin
          q_rp[i] <= q_rp[i] + 2'h1;
        end
        q_cnt[i] <= q_cnt[i] + {2'h0, q_push[i]} - {2'h0, q_pop[i]};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Working registers: datapath wins over bus
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      acc_first_r <= 8'h00;
      acc_second_r <= 8'h00;
      operand_reg_first_r <= 8'h00;
      operand_reg_second_r <= 8'h00;
      carry_r <= 1'b0;
      shout_r <= 1'b0;
    end else begin
      if (dp_act && cfg.dest[0]) begin
        acc_first_r <= alu_res;
      end else if (wr_go && wa == ADDR_ACC_FIRST) begin
        acc_first_r <= 8'(strb_merge({24'h0, acc_first_r}, wdata_r, wstrb_r));
      end
      if (dp_act && cfg.dest[1]) begin
        acc_second_r <= alu_res;
      end else if (wr_go && wa == ADDR_ACC_SECOND) begin
        acc_second_r <= 8'(strb_merge({24'h0, acc_second_r}, wdata_r, wstrb_r));
      end
      if (dp_pop[0]) begin
        operand_reg_first_r <= q_head[0];
      end else if (wr_go && wa == ADDR_OPR_FIRST) begin
        operand_reg_first_r <= 8'(strb_merge({24'h0, operand_reg_first_r}, wdata_r, wstrb_r));
      end
      if (dp_pop[1]) begin
        operand_reg_second_r <= q_head[1];
      end else if (wr_go && wa == ADDR_OPR_SECOND) begin
        operand_reg_second_r <= 8'(strb_merge({24'h0, operand_reg_second_r}, wdata_r, wstrb_r));
      end
      if (dp_act) begin
        carry_r <= cout;
        shout_r <= so;
      end
    end
  end

  // Configuration registers
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      ctrl_r <= CTRL_RST;
      latm_r <= LATCH_RST;
      setup_r <= SETUP_RST;
      poly_r <= POLY_RST;
      outsel_r <= OUTSEL_RST;
      cmpmask_r <= CMPMASK_RST;
      clken_r <= CLKEN_RST;
      ormask_r <= ORMASK_RST;
      for (int k = 0; k < 8; k++) begin
        cfg_ram[k] <= CFG_RST;
      end
    end else if (wr_go) begin
      if (wa == ADDR_CTRL) ctrl_r <= 8'(strb_merge({24'h0, ctrl_r}, wdata_r, wstrb_r));
      if (wa == ADDR_LATCH) latm_r <= 8'(strb_merge({24'h0, latm_r}, wdata_r, wstrb_r));
      if (wa == ADDR_SETUP) setup_r <= 10'(strb_merge({22'h0, setup_r}, wdata_r, wstrb_r));
      if (wa == ADDR_POLY) poly_r <= 8'(strb_merge({24'h0, poly_r}, wdata_r, wstrb_r));
      if (wa == ADDR_OUTSEL) outsel_r <= 24'(strb_merge({8'h0, outsel_r}, wdata_r, wstrb_r));
      if (wa == ADDR_CMPMASK) cmpmask_r <= 16'(strb_merge({16'h0, cmpmask_r}, wdata_r, wstrb_r));
      if (wa == ADDR_CLKEN) clken_r <= 8'(strb_merge({24'h0, clken_r}, wdata_r, wstrb_r));
      if (wa == ADDR_ORMASK) ormask_r <= 8'(strb_merge({24'h0, ormask_r}, wdata_r, wstrb_r));
      if (wa[7:5] == ADDR_CFG_BASE[7:5] && wa[1:0] == 2'h0) begin
        cfg_ram[wa[4:2]] <= 16'(strb_merge({16'h0, cfg_ram[wa[4:2]]}, wdata_r, wstrb_r));
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status capture, set wins over read clear
  assign stat_raw = {status_in, cond[COND_LT1:COND_EQ0]};
  assign stat_view = (stat_raw & ~latm_r) | (sticky_r & latm_r);
  assign stat_rd = rd_go && ra == ADDR_STAT;

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      sticky_r <= 8'h00;
    end else if (st_act) begin
      sticky_r <= (sticky_r & ~(stat_rd ? latm_r : 8'h00)) | (stat_raw & latm_r);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave
  always_comb begin
    rd_val = 32'h0;
    case (ra)
      ADDR_ACC_FIRST: rd_val = {24'h0, acc_first_r};
      ADDR_ACC_SECOND: rd_val = {24'h0, acc_second_r};
      ADDR_OPR_FIRST: rd_val = {24'h0, operand_reg_first_r};
      ADDR_OPR_SECOND: rd_val = {24'h0, operand_reg_second_r};
      ADDR_QUE_FIRST: rd_val = {24'h0, (setup_r[0] && !q_empty[0]) ? q_head[0] : 8'h00};
      ADDR_QUE_SECOND: rd_val = {24'h0, (setup_r[1] && !q_empty[1]) ? q_head[1] : 8'h00};
      ADDR_CTRL: rd_val = {24'h0, ctrl_r};
      ADDR_STAT: rd_val = {24'h0, stat_view};
      ADDR_LATCH: rd_val = {24'h0, latm_r};
      ADDR_SETUP: rd_val = {22'h0, setup_r};
      ADDR_POLY: rd_val = {24'h0, poly_r};
      ADDR_OUTSEL: rd_val = {8'h0, outsel_r};
      ADDR_CMPMASK: rd_val = {16'h0, cmpmask_r};
      ADDR_CLKEN: rd_val = {24'h0, clken_r};
      ADDR_ORMASK: rd_val = {24'h0, ormask_r};
      default: if (addr_ok(ra)) rd_val = {16'h0, cfg_ram[ra[4:2]]};
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      awready_r <= 1'b1;
      wready_r <= 1'b1;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
      awaddr_r <= 8'h00;
      wdata_r <= 32'h0;
      wstrb_r <= 4'h0;
    end else begin
      if (awready_r && axi_req.awvalid) begin
        awready_r <= 1'b0;
        awaddr_r <= axi_req.awaddr;
      end
      if (wready_r && axi_req.wvalid) begin
        wready_r <= 1'b0;
        wdata_r <= axi_req.wdata;
        wstrb_r <= axi_req.wstrb;
      end
      if (wr_go) begin
        bvalid_r <= 1'b1;
        bresp_r <= addr_ok(wa) ? RESP_OKAY : RESP_SLVERR;
      end
      if (bvalid_r && axi_req.bready) begin
        bvalid_r <= 1'b0;
        awready_r <= 1'b1;
        wready_r <= 1'b1;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      arready_r <= 1'b1;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0;
      rresp_r <= RESP_OKAY;
    end else if (rd_go) begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b1;
      rdata_r <= rd_val;
      rresp_r <= addr_ok(ra) ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_r && axi_req.rready) begin
      rvalid_r <= 1'b0;
      arready_r <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  sequence s_cfg0_written;
    wr_go && wa == ADDR_CFG_BASE && wstrb_r == 4'hF ##1 route_in[2:0] == 3'h0 && !wr_go;
  endsequence
  sequence s_full_push;
    wr_go && wa == ADDR_QUE_FIRST && wstrb_r[0] && !setup_r[0] && q_full[0] && !q_pop[0];
  endsequence

  AST_CFG_SELECT: assert property (s_cfg0_written |-> 16'(cfg) == $past(wdata_r[15:0]))
    else $error("active configuration differs from stored word");
  AST_LOGIC_AND: assert property (cfg.func == ALU_AND |-> alu_raw == (opa & opb))
    else $error("AND result wrong");
  AST_SWAP: assert property (cfg.shift == SH_SWAP && !cfg.crc_en && !cfg.mask_en && msb == 3'h7
    |-> alu_res == {alu_raw[3:0], alu_raw[7:4]})
    else $error("nibble swap wrong");
  AST_CRC_STEP: assert property (cfg.crc_en && !cfg.mask_en && msb == 3'h7 && !route_in[RIN_CRC]
    |-> alu_res == ({opa[6:0], 1'b0} ^ (opa[7] ? poly_r : 8'h00)))
    else $error("CRC step wrong");
  AST_ACC_LOAD: assert property (dp_act && cfg.dest[0] |=> acc_first_r == $past(alu_res))
    else $error("accumulator not loaded");
  AST_CARRY_HOLD: assert property (dp_act ##1 !dp_act |-> carry_r == $past(cout, 1))
    else $error("carry not registered");
  AST_QUEUE_FULL: assert property (s_full_push |=> q_cnt[0] == QDEPTH)
    else $error("full queue changed");
  AST_QUEUE_BOUND: assert property (q_cnt[0] <= QDEPTH && q_cnt[1] <= QDEPTH)
    else $error("queue count out of range");
  AST_STICKY_HOLD: assert property (sticky_r[0] && !stat_rd |=> sticky_r[0])
    else $error("latched status lost");
  AST_CTRL_DRIVE: assert property (wr_go && wa == ADDR_CTRL && wstrb_r[0]
    |=> ctrl_out == $past(wdata_r[7:0]))
    else $error("control output not updated");
  AST_ROUTE_OUT: assert property (rst_b |=> route_out[0] == $past(cond[outsel_r[3:0]]))
    else $error("routing output mismatch");
  AST_DP_GATE: assert property (!dp_act && !wr_go |=> $stable(acc_first_r))
    else $error("disabled datapath changed accumulator");
  AST_WRITE_RESP: assert property (wr_go |=> bvalid_r && !awready_r && !wready_r)
    else $error("write response missing");
endmodule : cltd_datapath
`default_nettype wire

/* File: testbench/cltd_bus_model.sv */
`timescale 1ns/1ps
`default_nettype none
module cltd_bus_model
  import cltd_pkg::*;
(
  input wire logic mclk,
  output var cltd_axi_req_s req,
  input wire cltd_axi_rsp_s rsp,
  output var logic tmo
);
  initial begin
    req = '0;
    tmo = 1'b0;
  end
  // Firmware write, address and data offered together
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge mclk);
    req.awvalid <= 1'b1;
    req.awaddr <= a;
    req.wvalid <= 1'b1;
    req.wdata <= d;
    req.wstrb <= 4'hF;
    req.bready <= 1'b1;
    for (n = 0; n < 64 && !rsp.bvalid; n++) begin
      @(posedge mclk);
      if (rsp.awready) req.awvalid <= 1'b0;
      if (rsp.wready) req.wvalid <= 1'b0;
    end
    req.bready <= 1'b0;
    r = rsp.bresp;
    if (n == 64) tmo <= 1'b1;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge mclk);
    req.arvalid <= 1'b1;
    req.araddr <= a;
    req.rready <= 1'b1;
    for (n = 0; n < 64 && !rsp.rvalid; n++) begin
      @(posedge mclk);
      if (rsp.arready) req.arvalid <= 1'b0;
    end
    req.rready <= 1'b0;
    d = rsp.rdata;
    r = rsp.rresp;
    if (n == 64) tmo <= 1'b1;
  endtask : rd
endmodule : cltd_bus_model
`default_nettype wire

/* File: testbench/cltd_datapath_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module cltd_datapath_bench
  import cltd_pkg::*;
;
  typedef struct packed {logic [7:0] a; logic [31:0] d; logic [1:0] r;} cltd_row_s;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  cltd_axi_req_s axi_req;
  cltd_axi_rsp_s axi_rsp;
  logic [5:0] route_in = 6'h00;
  logic [5:0] route_out;
  cltd_chain_s chain_in = '0;
  cltd_chain_s chain_out;
  logic [3:0] status_in = 4'hA;
  logic [7:0] ctrl_out;
  logic [1:0] pld_clk_en;
  logic tmo;
  logic [31:0] rdat;
  logic [1:0] resp;
  int n_fail = 0;
  int check_count = 0;
  cltd_row_s rows [7] = '{'{ADDR_CTRL, {24'h0, CTRL_RST}, RESP_OKAY},
    '{ADDR_SETUP, {22'h0, SETUP_RST}, RESP_OKAY}, '{ADDR_CMPMASK, {16'h0, CMPMASK_RST}, RESP_OKAY},
    '{ADDR_CLKEN, {24'h0, CLKEN_RST}, RESP_OKAY}, '{ADDR_STAT, 32'hA5, RESP_OKAY},
    '{8'h3C, 32'h0, RESP_SLVERR}, '{8'h19, 32'h0, RESP_SLVERR}};
  always #2.5 mclk = ~mclk;
  cltd_datapath u_dut (.mclk(mclk), .rst_b(rst_b), .axi_req(axi_req), .axi_rsp(axi_rsp),
    .route_in(route_in), .route_out(route_out), .chain_in(chain_in), .chain_out(chain_out),
    .status_in(status_in), .ctrl_out(ctrl_out), .pld_clk_en(pld_clk_en));
  cltd_bus_model u_bus (.mclk(mclk), .req(axi_req), .rsp(axi_rsp), .tmo(tmo));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
      n_fail++;
    end
  endtask : chk
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : report_and_stop
  always @(posedge mclk) begin
    if (tmo) begin
      n_fail++;
      report_and_stop();
    end
  end
  initial begin
    repeat (12) @(posedge mclk);
    rst_b <= 1'b1;
    foreach (rows[i]) begin
      u_bus.rd(rows[i].a, rdat, resp);
      chk(rdat, rows[i].d);
      chk({30'h0, resp}, {30'h0, rows[i].r});
    end
    chk({30'h0, pld_clk_en}, 32'h3);
    chk({27'h0, chain_out}, 32'h05);
    $display("test register table done");
    u_bus.wr(ADDR_CTRL, 32'h5A, resp);
    repeat (2) @(negedge mclk);
    chk({24'h0, ctrl_out}, 32'h5A);
    u_bus.wr(ADDR_STAT, 32'hFF, resp);
    status_in <= 4'h3;
    u_bus.rd(ADDR_STAT, rdat, resp);
    chk(rdat, 32'h35);
    $display("test control and status done");
    u_bus.wr(ADDR_OPR_FIRST, 32'h3, resp);
    u_bus.wr(ADDR_ACC_FIRST, 32'h5, resp);
    u_bus.wr(ADDR_CFG_BASE, 32'h0082, resp);
    u_bus.wr(ADDR_CFG_BASE + 8'h04, 32'h0086, resp);
    @(posedge mclk);
    route_in <= 6'h20;
    @(posedge mclk);
    route_in <= 6'h21;
    @(posedge mclk);
    route_in <= 6'h00;
    u_bus.rd(ADDR_ACC_FIRST, rdat, resp);
    chk(rdat, 32'h0B);
    $display("test alu sequence done");
    u_bus.wr(ADDR_OUTSEL, 32'hA, resp);
    for (int i = 0; i < 5; i++) begin
      u_bus.wr(ADDR_QUE_FIRST, 32'h11 + i, resp);
      repeat (2) @(negedge mclk);
      chk({30'h0, resp}, {30'h0, RESP_OKAY});
      chk({31'h0, route_out[0]}, {31'h0, i >= 3});
    end
    $display("test queue fill done");
    u_bus.wr(ADDR_LATCH, 32'h10, resp);
    status_in <= 4'h0;
    u_bus.rd(ADDR_STAT, rdat, resp);
    chk(rdat, 32'h14);
    u_bus.rd(ADDR_STAT, rdat, resp);
    chk(rdat, 32'h04);
    $display("test latched status done");
    report_and_stop();
  end
endmodule : cltd_datapath_bench
`default_nettype wire
